// ===== sim/ile_core_props.sv
// Checker of bus answers and interlock pins at the core ports
`timescale 1ns/1ps
`include "ile_regs.vh"
module ile_core_props (
  input wire        aclk,                 // Clock
  input wire        aresetn,              // Reset, active low
  input wire [15:0] araddr,               // Read address
  input wire        arvalid,              // Read address valid
  input wire        arready,              // Read address ready
  input wire [31:0] rdata,                // Read data
  input wire [1:0]  rresp,                // Read response
  input wire        rvalid,               // Read data valid
  input wire        rready,               // Read data ready
  input wire        bvalid,               // Write response valid
  input wire        bready,               // Write response ready
  input wire        interlock_flag_pin_a, // Interlock under way
  input wire        interlock_flag_pin_b  // Interlock hold
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus answer timing and content
  AST_R_LAT: assert property (arvalid && arready |-> ##2 rvalid)
    else $error("read answer not two cycles after address");
  AST_R_UNMAP: assert property (arvalid && arready && araddr == 16'h0FFC
    |-> ##2 rresp == `ILE_RESP_ERR && rdata == 32'h00000000)
    else $error("unmapped read not refused");
  AST_R_STAT: assert property (arvalid && arready && araddr == `ILE_OFF_STATUS
    |-> ##2 rresp == `ILE_RESP_OK && !rdata[`ILE_ST_BUSY])
    else $error("status read wrong");
  AST_R_ONE: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer repeated");
  AST_B_ONE: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer repeated");
  // Interlock pin behaviour
  AST_PIN_HOLD: assert property (interlock_flag_pin_a && interlock_flag_pin_b
    |=> interlock_flag_pin_a)
    else $error("interlock ended while held");
  AST_PIN_END: assert property (interlock_flag_pin_a && !interlock_flag_pin_b
    |=> !interlock_flag_pin_a)
    else $error("interlock longer than one cycle");
  AST_PIN_CAUSE: assert property ($rose(interlock_flag_pin_a) |-> $past(bvalid))
    else $error("interlock without instruction");
  AST_PIN_NORD: assert property (interlock_flag_pin_a |-> !arready)
    else $error("read taken while executing");
  // Main scenarios
  COV_HOLD: cover property (interlock_flag_pin_a && interlock_flag_pin_b);
  COV_UNMAP: cover property (arvalid && arready && araddr == 16'h0FFC);
  COV_WR: cover property (bvalid && bready);
endmodule // ile_core_props

bind ile_core ile_core_props props_u (.aclk(aclk), .aresetn(aresetn), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready), .bvalid(bvalid), .bready(bready),
  .interlock_flag_pin_a(interlock_flag_pin_a), .interlock_flag_pin_b(interlock_flag_pin_b));

// ===== sim/ile_xf_party.sv
// Far party that holds interlocked loads for a set number of cycles
`timescale 1ns/1ps
module ile_xf_party (
  input  wire       aclk,     // Clock
  input  wire       aresetn,  // Reset, active low
  input  wire [3:0] hold_n,   // Cycles to hold each load
  input  wire       flag_in,  // Interlock flag from core
  output wire       flag_out  // Hold flag to core
);
  reg [3:0] cnt_q;
  // Hold while fewer than hold_n cycles spent
  assign flag_out = flag_in && (cnt_q < hold_n);
  // Cycles of the current interlocked load
  always @(posedge aclk) begin
    if (!aresetn || !flag_in)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_q + 4'h1;
  end
endmodule // ile_xf_party

// ===== sim/integer_load_execution_tb.sv
// Self-checking bench of the integer load execution block
`timescale 1ns/1ps
`include "ile_regs.vh"
`define CHK(nm, e, g) begin samples_checked = samples_checked + 1; if ((g) !== (e)) begin \
  fails = fails + 1; $display("unexpected %s exp %h got %h", nm, e, g); end end
module integer_load_execution_tb;
  reg         aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg         arvalid = 1'b0, rready = 1'b0;
  reg  [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  reg  [31:0] wdata = 32'h00000000, v;
  reg  [3:0]  hold_n = 4'h0;
  reg  [1:0]  r;
  reg  [6:0]  f;
  reg  [4:0]  c;
  wire        awready, wready, bvalid, arready, rvalid, pin_a, pin_b;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  integer     fails = 0, samples_checked = 0, cyc = 0, pin_cnt = 0, p0, k;

  always #50 aclk = ~aclk;
  // Watchdog and interlock pin cycle count
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (pin_a)
      pin_cnt = pin_cnt + 1;
    if (cyc == 30000) begin
      fails = fails + 1;
      report_and_stop;
    end
  end

  ile_core dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .interlock_flag_pin_a(pin_a), .interlock_flag_pin_b(pin_b));
  ile_xf_party party_u (.aclk(aclk), .aresetn(aresetn), .hold_n(hold_n), .flag_in(pin_a),
    .flag_out(pin_b));

  // Bus write, waits for the response
  task axw(input [15:0] a, input [31:0] d);
    reg done;
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'b111;
      done = 1'b0;
      while (!done) begin
        @(posedge aclk);
        if (awready)
          awvalid <= 1'b0;
        if (wready)
          wvalid <= 1'b0;
        if (bvalid) begin
          r = bresp;
          bready <= 1'b0;
          done = 1'b1;
        end
      end
    end
  endtask
  // Bus read, result in v and r
  task axr(input [15:0] a);
    reg done;
    begin
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'b11;
      done = 1'b0;
      while (!done) begin
        @(posedge aclk);
        if (arready)
          arvalid <= 1'b0;
        if (rvalid) begin
          v = rdata;
          r = rresp;
          rready <= 1'b0;
          done = 1'b1;
        end
      end
    end
  endtask
  task wreg(input [4:0] n, input [31:0] d);
    axw(16'h0100 + {9'h000, n, 2'b00}, d);
  endtask
  task wmem(input [7:0] a, input [31:0] d);
    axw(16'h1000 + {6'h00, a, 2'b00}, d);
  endtask
  // Start an instruction and wait until idle
  task run(input [31:0] ins);
    begin
      axw(`ILE_OFF_INSTR, ins);
      axr(`ILE_OFF_STATUS);
      while (v[`ILE_ST_BUSY] !== 1'b0)
        axr(`ILE_OFF_STATUS);
    end
  endtask
  task creg(input [4:0] n, input [31:0] e);
    begin
      axr(16'h0100 + {9'h000, n, 2'b00});
      `CHK("cpu reg", e, v)
    end
  endtask
  task cst(input ill, input [6:0] fl);
    begin
      axr(`ILE_OFF_STATUS);
      `CHK("status", {ill, 2'b00, fl}, v[9:0])
    end
  endtask
  // Condition outcome from flags, codes above 19 never true
  function cond_ok(input [4:0] cc, input [6:0] x);
    reg cf, vf, zf, nf, un, lo, lu;
    reg [19:0] t;
    begin
      {lu, lo, un, nf, zf, vf, cf} = x;
      t = {zf | un, lu, ~lu, lo, ~lo, un, ~un, vf, ~vf, ~nf, ~nf & ~zf, nf | zf, nf, ~zf, zf,
           ~cf, ~cf & ~zf, cf | zf, cf, 1'b1};
      cond_ok = (cc < 5'h14) ? t[cc] : 1'b0;
    end
  endfunction
  task report_and_stop;
    begin
      if (fails == 0 && samples_checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values and unmapped accesses
    axr(`ILE_OFF_CTRL);
    `CHK("ctrl", 32'h00000000, v)
    cst(1'b0, `ILE_FLAGS_RST);
    axr(16'h0FFC);
    `CHK("rresp", `ILE_RESP_ERR, r)
    axw(16'h0FFC, 32'h12345678);
    `CHK("bresp", `ILE_RESP_ERR, r)
    // Plain loads, flag effects, saturation bit set midway
    axw(`ILE_OFF_STATUS, 32'h00000063);
    run({`ILE_OP_LOAD, `ILE_G_IMM, 5'h02, 16'hFF85});
    creg(5'h02, 32'hFFFFFF85);
    cst(1'b0, 7'h69);
    axw(`ILE_OFF_CTRL, 32'h00000001);
    run({`ILE_OP_LOAD, `ILE_G_IMM, 5'h03, 16'h0000});
    creg(5'h03, 32'h00000000);
    cst(1'b0, 7'h65);
    run({`ILE_OP_LOAD, `ILE_G_IMM, `ILE_R_AP0, 16'h0005});
    creg(`ILE_R_AP0, 32'h00000005);
    cst(1'b0, 7'h65);
    // Register, direct and indirect sources
    run({`ILE_OP_LOAD, `ILE_G_REG, 5'h06, 16'h0002});
    creg(5'h06, 32'hFFFFFF85);
    wmem(8'h44, 32'h80000000);
    run({`ILE_OP_LOAD, `ILE_G_DIR, 5'h07, 16'h0044});
    creg(5'h07, 32'h80000000);
    run({`ILE_OP_LOAD, `ILE_G_IND, 5'h01, 16'h003F});
    creg(5'h01, 32'h80000000);
    cst(1'b0, 7'h69);
    // Interlocked loads, prompt and held, then refused modes
    for (k = 0; k < 4; k = k + 3) begin
      hold_n <= k[3:0];
      p0 = pin_cnt;
      run({`ILE_OP_ILOAD, `ILE_G_DIR, 5'h05, 16'h0044});
      `CHK("pin cycles", k + 1, pin_cnt - p0)
      creg(5'h05, 32'h80000000);
    end
    for (k = 0; k < 4; k = k + 3) begin
      run({`ILE_OP_ILOAD, k[1:0], 5'h05, 16'h0001});
      creg(5'h05, 32'h80000000);
      cst(1'b1, 7'h69);
    end
    // Every condition on two flag patterns, post-modified pointer
    wreg(5'h09, 32'h00000020);
    for (k = 0; k < 42; k = k + 1)
      wmem(k[7:0] + 8'h20, 32'h00000300 + k);
    for (k = 0; k < 42; k = k + 1) begin
      f = (k < 21) ? 7'h55 : 7'h2A;
      c = k % 21;
      axw(`ILE_OFF_STATUS, {25'h0000000, f});
      wreg(5'h04, 32'h000000A5);
      run({`ILE_OP_COND, c, `ILE_G_IND, 5'h04, 16'h8101});
      creg(5'h04, cond_ok(c, f) ? 32'h00000300 + k : 32'h000000A5);
      cst(1'b0, f);
    end
    creg(5'h09, 32'h0000004A);
    // Parallel forms: same target, register source, load with store
    wreg(5'h0A, 32'h00000050);
    wmem(8'h50, 32'h00000011);
    wreg(5'h0B, 32'h00000051);
    wmem(8'h51, 32'h00000022);
    axw(`ILE_OFF_STATUS, 32'h0000002C);
    run({2'b11, `ILE_OP_PLL, 3'h0, 3'h0, 3'h0, 8'h1A, 8'h1B});
    creg(5'h00, 32'h00000022);
    cst(1'b0, 7'h2C);
    run({2'b11, `ILE_OP_PLL, 3'h3, 3'h4, 3'h4, 8'h1A, 8'h06});
    creg(5'h03, 32'h00000000);
    cst(1'b1, 7'h2C);
    axw(`ILE_OFF_CTRL, 32'h00000003);
    run({2'b11, `ILE_OP_PLL, 3'h3, 3'h4, 3'h4, 8'h1A, 8'h06});
    creg(5'h03, 32'h00000011);
    creg(5'h04, 32'hFFFFFF85);
    run({2'b11, `ILE_OP_PLS, 3'h1, 3'h7, 3'h0, 8'h1A, 8'h1A});
    creg(5'h01, 32'h00000011);
    axr(16'h1140);
    `CHK("stored word", 32'h80000000, v)
    cst(1'b0, 7'h2C);
    report_and_stop;
  end
endmodule // integer_load_execution_tb

// ===== src/ile_core.v
// Integer load execution unit with AXI4-Lite register access
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "ile_regs.vh"
//
// Contract
// - Plain load decodes from top opcode bits, mode, destination and source fields.
// - Mode 00 register, 01 direct, 10 indirect, 11 immediate.
// - Plain load copies the signed source into any destination register.
// - Plain and interlocked loads touch flags only for destinations R0 to R7.
// - Such loads set N and Z from result, clear V, keep latched flags and carry.
// - Saturation mode bit never changes any load behaviour.
// - Conditional load writes destination only when its condition is true.
// - Conditional load always performs its source read, memory included.
// - Twenty condition codes, each testing the current flags.
// - Conditional load leaves every flag unchanged.
// - Flags come only from extended-register destinations or compares.
// - Pointer pre or post modification happens whatever the condition.
// - Interlocked load signals on the flag pins while loading signed source.
// - Interlocked load accepts only direct and indirect modes.
// - Interlocked load ends in one cycle with input flag low; else waits.
// - Parallel load pair into R0 to R7; same target, second source wins.
// - Later revision lets the second parallel source be any register.
// - Load with store in one cycle; read happens before the write.
module ile_core #(
  parameter AW = 8                        // Data memory word address width
) (
  input  wire        aclk,                // Clock, 10 MHz
  input  wire        aresetn,             // Synchronous reset, active low
  input  wire [15:0] awaddr,              // Write address
  input  wire        awvalid,             // Write address valid
  output wire        awready,             // Write address ready
  input  wire [31:0] wdata,               // Write data
  input  wire [3:0]  wstrb,               // Write byte strobes
  input  wire        wvalid,              // Write data valid
  output wire        wready,              // Write data ready
  output reg  [1:0]  bresp,               // Write response
  output reg         bvalid,              // Write response valid
  input  wire        bready,              // Write response ready
  input  wire [15:0] araddr,              // Read address
  input  wire        arvalid,             // Read address valid
  output wire        arready,             // Read address ready
  output reg  [31:0] rdata,               // Read data
  output reg  [1:0]  rresp,               // Read response
  output reg         rvalid,              // Read data valid
  input  wire        rready,              // Read data ready
  output reg         interlock_flag_pin_a,// Interlocked operation under way
  input  wire        interlock_flag_pin_b // Interlock hold input, high stalls
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_FETCH = 2'd1;
  localparam ST_EXEC  = 2'd2;
  reg  [1:0]  st_q;
  reg  [31:0] instr_q;
  reg  [1:0]  ctrl_q;
  reg  [6:0]  flags_q;
  reg         ill_q;
  reg  [31:0] cpu_q [0:31];
  reg         aw_full_q;
  reg         w_full_q;
  reg  [15:0] aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         rpend_q;
  reg  [15:0] rd_addr_q;
  wire [31:0] mem_a_data;
  wire [31:0] mem_b_data;
  // Byte-lane merge of a bus write
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    reg   [31:0] lane;
    begin
      lane  = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      merge = (nw & lane) | (old & ~lane);
    end
  endfunction
  // Index offset: disp, index reg A or B; parallel form has disp 1 or 0
  function [31:0] ind_off;
    input [1:0]  sel;
    input [7:0]  disp;
    input [31:0] ixa;
    input [31:0] ixb;
    input        par;
    begin
      ind_off = (sel == 2'b01) ? ixa : (sel == 2'b10) ? ixb :
                par ? {31'h00000000, (sel == 2'b00)} : {24'h000000, disp};
    end
  endfunction
  // Pointer plus or minus offset
  function [31:0] ind_step;
    input [4:0]  md;
    input [31:0] base;
    input [31:0] off;
    begin
      ind_step = md[2] ? base - off : base + off;
    end
  endfunction
  // Condition test on current flags, twenty codes
  function cond_true;
    input [4:0] cc;
    input [6:0] f;
    begin
      case (cc)
        5'h00: cond_true = 1'b1;
        5'h01: cond_true = f[`ILE_F_C];
        5'h02: cond_true = f[`ILE_F_C] | f[`ILE_F_Z];
        5'h03: cond_true = ~f[`ILE_F_C] & ~f[`ILE_F_Z];
        5'h04: cond_true = ~f[`ILE_F_C];
        5'h05: cond_true = f[`ILE_F_Z];
        5'h06: cond_true = ~f[`ILE_F_Z];
        5'h07: cond_true = f[`ILE_F_N];
        5'h08: cond_true = f[`ILE_F_N] | f[`ILE_F_Z];
        5'h09: cond_true = ~f[`ILE_F_N] & ~f[`ILE_F_Z];
        5'h0A: cond_true = ~f[`ILE_F_N];
        5'h0B: cond_true = ~f[`ILE_F_V];
        5'h0C: cond_true = f[`ILE_F_V];
        5'h0D: cond_true = ~f[`ILE_F_UNF];
        5'h0E: cond_true = f[`ILE_F_UNF];
        5'h0F: cond_true = ~f[`ILE_F_LOVF];
        5'h10: cond_true = f[`ILE_F_LOVF];
        5'h11: cond_true = ~f[`ILE_F_LUNF];
        5'h12: cond_true = f[`ILE_F_LUNF];
        5'h13: cond_true = f[`ILE_F_Z] | f[`ILE_F_UNF];
        default: cond_true = 1'b0;
      endcase
    end
  endfunction
  // Instruction decode
  wire [1:0]  g_mode  = instr_q[22:21];
  wire [4:0]  dst     = instr_q[20:16];
  wire [15:0] src     = instr_q[15:0];
  wire is_ld   = (instr_q[31:23] == `ILE_OP_LOAD);
  wire is_lii  = (instr_q[31:23] == `ILE_OP_ILOAD);
  wire is_ldc  = (instr_q[31:28] == `ILE_OP_COND);
  wire is_par  = (instr_q[31:30] == `ILE_OP_PAR);
  wire is_pll  = is_par && (instr_q[29:25] == `ILE_OP_PLL);
  wire is_pls  = is_par && (instr_q[29:25] == `ILE_OP_PLS);
  wire is_gen  = is_ld || is_lii || is_ldc;
  wire b_isreg = instr_q[18];
  wire ill_dec = !(is_gen || is_pll || is_pls) ||
                 (is_lii && (g_mode == `ILE_G_REG || g_mode == `ILE_G_IMM)) ||
                 ((is_pll || is_pls) && b_isreg && !ctrl_q[`ILE_CTRL_REV]);
  // Indirect fields: port A in bits 15:8, port B in bits 7:0
  wire [4:0]  a_md   = src[15:11];
  wire [31:0] a_base = cpu_q[`ILE_R_AP0 + {2'b00, src[10:8]}];
  wire [31:0] a_off  = ind_off(a_md[1:0], src[7:0], cpu_q[`ILE_R_IXA],
                               cpu_q[`ILE_R_IXB], is_par);
  wire [31:0] a_upd  = ind_step(a_md, a_base, a_off);
  wire [31:0] a_ea   = (a_md[4:3] == 2'b10) ? a_base : a_upd;
  wire        a_mod  = (a_md[4:3] == 2'b01) || (a_md[4:3] == 2'b10);
  wire [4:0]  b_md   = src[7:3];
  wire [31:0] b_base = cpu_q[`ILE_R_AP0 + {2'b00, src[2:0]}];
  wire [31:0] b_off  = ind_off(b_md[1:0], 8'h00, cpu_q[`ILE_R_IXA],
                               cpu_q[`ILE_R_IXB], 1'b1);
  wire [31:0] b_upd  = ind_step(b_md, b_base, b_off);
  wire [31:0] b_ea   = (b_md[4:3] == 2'b10) ? b_base : b_upd;
  wire        b_mod  = (b_md[4:3] == 2'b01) || (b_md[4:3] == 2'b10);
  // Direct address from page pointer and offset
  wire [31:0] dir_ea = {8'h00, cpu_q[`ILE_R_PAGE][7:0], src};
  wire [31:0] x_a_ea = (is_gen && g_mode == `ILE_G_DIR) ? dir_ea : a_ea;
  // General source value by mode
  reg [31:0] gen_src;
  always @* begin
    case (g_mode)
      `ILE_G_REG: gen_src = cpu_q[src[4:0]];
      `ILE_G_IMM: gen_src = {{16{src[15]}}, src};
      default:    gen_src = mem_a_data;
    endcase
  end
  wire [31:0] par_b_src = b_isreg ? cpu_q[src[4:0]] : mem_b_data;
  // Execution timing
  wire exec_go   = (st_q == ST_EXEC) && !(is_lii && interlock_flag_pin_b);
  wire gen_mem   = is_gen && (g_mode == `ILE_G_DIR || g_mode == `ILE_G_IND);
  wire gen_ind   = is_gen && (g_mode == `ILE_G_IND);
  wire ldc_pass  = cond_true(instr_q[27:23], flags_q);
  wire idle      = (st_q == ST_IDLE);
  // Bus transfers: read addresses accepted and writes applied only while idle
  wire do_wr     = aw_full_q && w_full_q && !bvalid && idle;
  wire do_rd     = arvalid && arready;
  assign awready = !aw_full_q;
  assign wready  = !w_full_q;
  assign arready = idle && !rpend_q && !rvalid;
  // Bus address decode
  wire wr_instr  = (aw_addr_q == `ILE_OFF_INSTR);
  wire wr_ctrl   = (aw_addr_q == `ILE_OFF_CTRL);
  wire wr_stat   = (aw_addr_q == `ILE_OFF_STATUS);
  wire wr_reg    = (aw_addr_q[15:7] == `ILE_REGWIN_TAG);
  wire wr_mem    = (aw_addr_q[15:12] == `ILE_MEMWIN_TAG) && ((aw_addr_q[11:2] >> AW) == 10'd0);
  wire wr_ok     = wr_instr || wr_ctrl || wr_stat || wr_reg || wr_mem;
  wire rd_mem    = (rd_addr_q[15:12] == `ILE_MEMWIN_TAG) && ((rd_addr_q[11:2] >> AW) == 10'd0);
  // Memory ports: execution reads in fetch and writes in exec, bus otherwise
  wire          fetch = (st_q == ST_FETCH);
  wire [AW-1:0] m_a_addr = fetch ? x_a_ea[AW-1:0] : araddr[AW+1:2];
  wire          m_a_en = (fetch && (gen_mem || is_pll || is_pls)) || do_rd;
  wire          m_w_en = (exec_go && is_pls && !ill_q) || (do_wr && wr_mem);
  wire [AW-1:0] m_w_addr = (st_q == ST_EXEC) ? a_ea[AW-1:0] : aw_addr_q[AW+1:2];
  wire [31:0]   m_w_data = (st_q == ST_EXEC) ? cpu_q[{2'b00, instr_q[21:19]}] :
                                               merge(32'h00000000, w_data_q, w_strb_q);
  ile_dmem #(.AW (AW), .DW (32)) u_dmem (
    .clk    (aclk),
    .a_en   (m_a_en),
    .a_addr (m_a_addr),
    .a_data (mem_a_data),
    .b_en   (fetch && (is_pll || is_pls) && !b_isreg),
    .b_addr (b_ea[AW-1:0]),
    .b_data (mem_b_data),
    .w_en   (m_w_en),
    .w_addr (m_w_addr),
    .w_data (m_w_data)
  );

  // Instruction sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q                 <= ST_IDLE;
      ill_q                <= 1'b0;
      interlock_flag_pin_a <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (do_wr && wr_instr) begin
            st_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          ill_q                <= ill_dec;
          interlock_flag_pin_a <= is_lii && !ill_dec;
          st_q                 <= ill_dec ? ST_IDLE : ST_EXEC;
        end
        ST_EXEC: begin
          if (exec_go) begin
            interlock_flag_pin_a <= 1'b0;
            st_q                 <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Architectural state: instruction, control, flags and register file
  integer i;
  always @(posedge aclk) begin
    if (!aresetn) begin
      instr_q <= `ILE_INSTR_RST;
      ctrl_q  <= `ILE_CTRL_RST;
      flags_q <= `ILE_FLAGS_RST;
      for (i = 0; i < 32; i = i + 1) begin
        cpu_q[i] <= 32'h00000000;
      end
    end else begin
      if (do_wr) begin
        if (wr_instr) begin
          instr_q <= merge(instr_q, w_data_q, w_strb_q);
        end else if (wr_ctrl) begin
          ctrl_q <= w_strb_q[0] ? w_data_q[1:0] : ctrl_q;
        end else if (wr_stat) begin
          flags_q <= w_strb_q[0] ? w_data_q[6:0] : flags_q;
        end else if (wr_reg) begin
          cpu_q[aw_addr_q[6:2]] <= merge(cpu_q[aw_addr_q[6:2]], w_data_q, w_strb_q);
        end
      end
      if (exec_go) begin
        // Pointer updates first, so a load into the same slot wins
        if ((gen_ind || is_pll || is_pls) && a_mod) begin
          cpu_q[`ILE_R_AP0 + {2'b00, src[10:8]}] <= a_upd;
        end
        if ((is_pll || is_pls) && !b_isreg && b_mod) begin
          cpu_q[`ILE_R_AP0 + {2'b00, src[2:0]}] <= b_upd;
        end
        if (is_ld || is_lii || (is_ldc && ldc_pass)) begin
          cpu_q[dst] <= gen_src;
        end
        if ((is_ld || is_lii) && dst <= `ILE_R_EXT_LAST) begin
          flags_q[`ILE_F_UNF:`ILE_F_V] <= {1'b0, gen_src[31], ~|gen_src, 1'b0};
        end
        if (is_pll) begin
          cpu_q[{2'b00, instr_q[24:22]}] <= mem_a_data;
          cpu_q[{2'b00, instr_q[21:19]}] <= par_b_src;
        end
        if (is_pls) begin
          cpu_q[{2'b00, instr_q[24:22]}] <= par_b_src;
        end
      end
    end
  end

  // Write channel capture and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= 16'h0000;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `ILE_RESP_OK;
    end else begin
      if (awvalid && awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= {awaddr[15:2], 2'b00};
      end
      if (wvalid && wready) begin
        w_full_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_ok ? `ILE_RESP_OK : `ILE_RESP_ERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read channel: address taken, data two cycles later
  always @(posedge aclk) begin
    if (!aresetn) begin
      rpend_q   <= 1'b0;
      rd_addr_q <= 16'h0000;
      rvalid    <= 1'b0;
      rdata     <= 32'h00000000;
      rresp     <= `ILE_RESP_OK;
    end else begin
      rpend_q <= do_rd;
      if (do_rd) begin
        rd_addr_q <= {araddr[15:2], 2'b00};
      end
      if (rpend_q) begin
        rvalid <= 1'b1;
        rresp  <= `ILE_RESP_OK;
        if (rd_addr_q == `ILE_OFF_INSTR) begin
          rdata <= instr_q;
        end else if (rd_addr_q == `ILE_OFF_CTRL) begin
          rdata <= {30'h0, ctrl_q};
        end else if (rd_addr_q == `ILE_OFF_STATUS) begin
          rdata <= {22'h0, ill_q, !idle, 1'b0, flags_q};
        end else if (rd_addr_q[15:7] == `ILE_REGWIN_TAG) begin
          rdata <= cpu_q[rd_addr_q[6:2]];
        end else if (rd_mem) begin
          rdata <= mem_a_data;
        end else begin
          rdata <= 32'h00000000;
          rresp <= `ILE_RESP_ERR;
        end
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule // ile_core

// ===== src/ile_dmem.v
// Data memory with two registered read ports and one write port
`timescale 1ns/1ps
module ile_dmem #(
  parameter AW = 8,                       // Word address width
  parameter DW = 32                       // Word width
) (
  input  wire          clk,               // Clock
  input  wire          a_en,              // Port A read enable
  input  wire [AW-1:0] a_addr,            // Port A read address
  output reg  [DW-1:0] a_data,            // Port A read data
  input  wire          b_en,              // Port B read enable
  input  wire [AW-1:0] b_addr,            // Port B read address
  output reg  [DW-1:0] b_data,            // Port B read data
  input  wire          w_en,              // Write enable
  input  wire [AW-1:0] w_addr,            // Write address
  input  wire [DW-1:0] w_data             // Write data
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Reads return the old word when a write hits the same address
  always @(posedge clk) begin
    if (a_en) begin
      a_data <= mem[a_addr];
    end
    if (b_en) begin
      b_data <= mem[b_addr];
    end
    if (w_en) begin
      mem[w_addr] <= w_data;
    end
  end

endmodule // ile_dmem

// ===== src/ile_regs.vh
// Offsets, field codes and reset values of the integer load execution block
`ifndef ILE_REGS_VH
`define ILE_REGS_VH

// Register bus byte offsets
`define ILE_OFF_INSTR     16'h0000
`define ILE_OFF_CTRL      16'h0004
`define ILE_OFF_STATUS    16'h0008
`define ILE_REGWIN_TAG    9'h002
`define ILE_MEMWIN_TAG    4'h1

// Reset values
`define ILE_CTRL_RST      2'h0
`define ILE_FLAGS_RST     7'h00
`define ILE_INSTR_RST     32'h00000000

// Control bits
`define ILE_CTRL_SAT      0
`define ILE_CTRL_REV      1

// Status flag positions
`define ILE_F_C           0
`define ILE_F_V           1
`define ILE_F_Z           2
`define ILE_F_N           3
`define ILE_F_UNF         4
`define ILE_F_LOVF        5
`define ILE_F_LUNF        6
`define ILE_ST_BUSY       8
`define ILE_ST_ILL        9

// Opcode fields
`define ILE_OP_LOAD       9'h010
`define ILE_OP_ILOAD      9'h011
`define ILE_OP_COND       4'h5
`define ILE_OP_PAR        2'h3
`define ILE_OP_PLL        5'h02
`define ILE_OP_PLS        5'h1D

// Source addressing modes
`define ILE_G_REG         2'h0
`define ILE_G_DIR         2'h1
`define ILE_G_IND         2'h2
`define ILE_G_IMM         2'h3

// Register file slots
`define ILE_R_EXT_LAST    5'h07
`define ILE_R_AP0         5'h08
`define ILE_R_PAGE        5'h10
`define ILE_R_IXA         5'h11
`define ILE_R_IXB         5'h12

// Bus responses
`define ILE_RESP_OK       2'h0
`define ILE_RESP_ERR      2'h2

`endif
